// ---- common/sinc3_pkg.sv ----
package sinc3_pkg;
  localparam logic [6:0] MOD_LAST = 7'h7f;
  localparam int FW_W = 12;
  localparam int ACC_W = 37;
  localparam int COEF_W = 24;
  localparam int CH_NUM = 4;
  localparam int CH_W = 2;
  localparam int GAIN_SH = 22;
  localparam int SETTLE_PERIODS = 3;
  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_PERIODS - 1);
  // Register addresses
  localparam logic [2:0] A_FILTER = 3'h0;
  localparam logic [2:0] A_MODE = 3'h1;
  localparam logic [2:0] A_STATUS = 3'h2;
  localparam logic [2:0] A_DATA = 3'h3;
  localparam logic [2:0] A_OFFSET = 3'h4;
  localparam logic [2:0] A_GAIN = 3'h5;
  // Field positions
  localparam int FILT_BIP = 12;
  localparam int FILT_W16 = 13;
  localparam int MODE_SYNC = 3;
  localparam int MODE_CH = 4;
  // Reset values, saturation ceiling and bipolar midscale
  localparam logic [11:0] FW_RST = 12'h100;
  localparam logic [23:0] OFF_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h400000;
  localparam logic [23:0] SAT_MAX = 24'hffffff;
  localparam logic [32:0] MID33 = 33'h000800000;
  // Divider exponents for unipolar and bipolar gain
  localparam logic [5:0] EXP_UNI = 6'h2e;
  localparam logic [5:0] EXP_BIP = 6'h2d;
  // Calibration mode codes
  localparam logic [2:0] CAL_NONE = 3'h0;
  localparam logic [2:0] CAL_FULL = 3'h1;
  localparam logic [2:0] CAL_SYS_ZS = 3'h2;
  localparam logic [2:0] CAL_SYS_FS = 3'h3;
  localparam logic [2:0] CAL_ZS = 3'h6;
  localparam logic [2:0] CAL_FS = 3'h7;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ZS = 2'b01,
    ST_FS = 2'b10,
    ST_DIV = 2'b11
  } cal_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

// ---- hdl/sinc3_decimator.sv ----
module sinc3_decimator (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Modulator stream and sync pin
  input wire logic mod_bit,
  input wire logic sync_n,
  // Register port
  input wire sinc3_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  // Result status
  output logic result_ready_flag
);
  import sinc3_pkg::*;

  // Shift that scales N cubed toward the top of the accumulator
  function automatic logic [5:0] norm_shift(input logic [FW_W-1:0] n);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < FW_W; i++)
    begin
      if (n[i])
        m = 4'(i);
    end
    return 6'(3 * (FW_W - 1 - int'(m)));
  endfunction

  // Clamp the 33-bit result into the 24-bit code range
  function automatic logic [COEF_W-1:0] sat24(input logic [32:0] v);
    if (v[32])
      return OFF_RST;
    else if (v[31:COEF_W] != 8'h00)
      return SAT_MAX;
    else
      return v[COEF_W-1:0];
  endfunction

  logic [1:0] bit_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [6:0] div_reg;
  logic [FW_W-1:0] dec_reg;
  logic [FW_W-1:0] fw_reg;
  logic bip_reg;
  logic w16_reg;
  logic [2:0] cal_mode_reg;
  logic sync_bit_reg;
  logic [CH_W-1:0] ch_reg;
  logic [ACC_W-1:0] i1_reg, i2_reg, i3_reg;
  logic [ACC_W-1:0] d1_reg, d2_reg, d3_reg;
  logic [ACC_W-1:0] f_reg;
  logic conv_vld_reg;
  logic [1:0] settle_reg;
  logic [COEF_W-1:0] data_reg;
  logic [COEF_W-1:0] off_mem [CH_NUM];
  logic [COEF_W-1:0] gain_mem [CH_NUM];
  cal_state_t state_reg;
  logic [25:0] rem_reg;
  logic [47:0] q_reg;
  logic [5:0] dcnt_reg;
  logic [COEF_W:0] d_reg;

  // Two-flop synchronisers for pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_sync_reg <= 2'h0;
      pin_sync_reg <= 2'h3;
    end
    else
    begin
      bit_sync_reg <= {bit_sync_reg[0], mod_bit};
      pin_sync_reg <= {pin_sync_reg[0], sync_n};
    end
  end

  // Register decode
  wire wr_filter = bus.wr && (bus.addr == A_FILTER);
  wire wr_mode = bus.wr && (bus.addr == A_MODE);
  wire wr_off = bus.wr && (bus.addr == A_OFFSET);
  wire wr_gain = bus.wr && (bus.addr == A_GAIN);
  wire rd_data = bus.rd && (bus.addr == A_DATA);
  wire [2:0] new_mode = bus.wdata[2:0];
  wire [CH_W-1:0] new_ch = bus.wdata[MODE_CH +: CH_W];
  wire cal_code = (new_mode == CAL_FULL) || (new_mode == CAL_ZS) ||
                  (new_mode == CAL_SYS_ZS);
  wire fs_code = (new_mode == CAL_FS) || (new_mode == CAL_SYS_FS);

  // Modulator rate and decimation strobes
  wire mod_en = (div_reg == MOD_LAST);
  wire dec_en = mod_en && (dec_reg == fw_reg - 12'h001);
  wire cal_step;
  wire hold = !pin_sync_reg[1] || sync_bit_reg;
  wire resync = hold || wr_filter || wr_mode || cal_step;

  // Modulator-rate divider
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_reg <= 7'h00;
    else
      div_reg <= div_reg + 7'h01;
  end

  // Integrators at modulator rate, decimation counter
  always_ff @(posedge clk)
  begin
    if (!rst_n || resync)
    begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      dec_reg <= '0;
    end
    else if (mod_en)
    begin
      i1_reg <= i1_reg + ACC_W'(bit_sync_reg[1]);
      i2_reg <= i2_reg + i1_reg;
      i3_reg <= i3_reg + i2_reg;
      dec_reg <= dec_en ? 12'h000 : dec_reg + 12'h001;
    end
  end

  // Comb stages at output rate; they take the integrator sum that already
  // holds the current sample, else the third output is one count short
  wire [ACC_W-1:0] i3_next = i3_reg + i2_reg;
  wire [ACC_W-1:0] c1 = i3_next - d1_reg;
  wire [ACC_W-1:0] c2 = c1 - d2_reg;
  wire [ACC_W-1:0] c3 = c2 - d3_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n || resync)
    begin
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      f_reg <= '0;
      conv_vld_reg <= 1'b0;
    end
    else
    begin
      conv_vld_reg <= dec_en;
      if (dec_en)
      begin
        d1_reg <= i3_next;
        d2_reg <= c1;
        d3_reg <= c2;
        f_reg <= c3;
      end
    end
  end

  // Settling: drop the first outputs after a resync
  wire accept = conv_vld_reg && (settle_reg == SETTLE_LAST);
  always_ff @(posedge clk)
  begin
    if (!rst_n || resync)
      settle_reg <= 2'h0;
    else if (conv_vld_reg && (settle_reg != SETTLE_LAST))
      settle_reg <= settle_reg + 2'h1;
  end

  // Normalization and correction datapath
  wire [5:0] sh = norm_shift(fw_reg);
  wire [ACC_W-1:0] f_sh = f_reg << sh;
  wire [COEF_W-1:0] x = f_sh[ACC_W-1 -: COEF_W];
  wire [COEF_W-1:0] off_sel = off_mem[ch_reg];
  wire [COEF_W-1:0] gain_sel = gain_mem[ch_reg];
  wire signed [COEF_W:0] diff = $signed({1'b0, x}) -
                                $signed({1'b0, off_sel});
  wire signed [2*COEF_W+1:0] prod = diff * $signed({1'b0, gain_sel});
  wire [32:0] base = bip_reg ? MID33 : 33'h000000000;
  wire [32:0] acc33 = {{5{prod[2*COEF_W+1]}},
                       prod[2*COEF_W+1:GAIN_SH]} + base;
  wire [COEF_W-1:0] res = sat24(acc33);
  wire [COEF_W-1:0] res_word = w16_reg ? {8'h00, res[COEF_W-1:8]} : res;

  // Full-scale divider step
  wire [25:0] div_t = {rem_reg[24:0], 1'b0};
  wire div_ge = div_t >= {1'b0, d_reg};
  wire [COEF_W-1:0] q_sat = (q_reg[47:COEF_W] != 24'h000000) ? SAT_MAX :
                            q_reg[COEF_W-1:0];
  wire [5:0] div_exp = bip_reg ? EXP_BIP : EXP_UNI;
  wire zs_done = (state_reg == ST_ZS) && accept;
  wire div_done = (state_reg == ST_DIV) && (dcnt_reg == 6'h00);
  wire fs_bad = (state_reg == ST_FS) && accept && (diff <= 0);
  assign cal_step = zs_done || div_done || fs_bad;

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fw_reg <= FW_RST;
      bip_reg <= 1'b0;
      w16_reg <= 1'b0;
      sync_bit_reg <= 1'b0;
      ch_reg <= '0;
    end
    else if (wr_filter)
    begin
      fw_reg <= bus.wdata[FW_W-1:0];
      bip_reg <= bus.wdata[FILT_BIP];
      w16_reg <= bus.wdata[FILT_W16];
    end
    else if (wr_mode)
    begin
      sync_bit_reg <= bus.wdata[MODE_SYNC];
      ch_reg <= new_ch;
    end
  end

  // Calibration sequencer; a mode write always takes priority
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
      cal_mode_reg <= CAL_NONE;
    end
    else if (wr_mode)
    begin
      cal_mode_reg <= new_mode;
      state_reg <= cal_code ? ST_ZS : (fs_code ? ST_FS : ST_RUN);
    end
    else
    begin
      unique case (state_reg)
        ST_RUN: state_reg <= ST_RUN;
        ST_ZS:
        begin
          if (accept && cal_mode_reg == CAL_FULL)
            state_reg <= ST_FS;
          else if (accept)
          begin
            state_reg <= ST_RUN;
            cal_mode_reg <= CAL_NONE;
          end
        end
        ST_FS:
        begin
          if (fs_bad)
          begin
            state_reg <= ST_RUN;
            cal_mode_reg <= CAL_NONE;
          end
          else if (accept)
            state_reg <= ST_DIV;
        end
        ST_DIV:
        begin
          if (div_done)
          begin
            state_reg <= ST_RUN;
            cal_mode_reg <= CAL_NONE;
          end
        end
      endcase
    end
  end

  // Gain divider: quotient of a power of two by the full-scale span
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rem_reg <= '0;
      q_reg <= '0;
      dcnt_reg <= 6'h00;
      d_reg <= '0;
    end
    else if ((state_reg == ST_FS) && accept)
    begin
      rem_reg <= 26'h0000001;
      q_reg <= '0;
      dcnt_reg <= div_exp;
      d_reg <= diff;
    end
    else if ((state_reg == ST_DIV) && (dcnt_reg != 6'h00))
    begin
      rem_reg <= div_ge ? div_t - {1'b0, d_reg} : div_t;
      q_reg <= {q_reg[46:0], div_ge};
      dcnt_reg <= dcnt_reg - 6'h01;
    end
  end

  // Per-channel coefficient store
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CH_NUM; i++)
      begin
        off_mem[i] <= OFF_RST;
        gain_mem[i] <= GAIN_RST;
      end
    end
    else if (wr_off)
      off_mem[ch_reg] <= bus.wdata[COEF_W-1:0];
    else if (wr_gain)
      gain_mem[ch_reg] <= bus.wdata[COEF_W-1:0];
    else if (zs_done)
      off_mem[ch_reg] <= x;
    else if (div_done)
      gain_mem[ch_reg] <= q_sat;
    else if (fs_bad)
      gain_mem[ch_reg] <= SAT_MAX;
  end

  // Data register and ready flag; a new word beats a read clear
  wire upd = accept && (state_reg == ST_RUN) && !wr_mode;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_reg <= '0;
      result_ready_flag <= 1'b0;
    end
    else if (upd)
    begin
      data_reg <= res_word;
      result_ready_flag <= 1'b1;
    end
    else if (rd_data || (wr_mode && (cal_code || fs_code)))
      result_ready_flag <= 1'b0;
  end

  // Read mux, answered in the next cycle only
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (bus.addr)
      A_FILTER: rd_mux = {18'h00000, w16_reg, bip_reg, fw_reg};
      A_MODE: rd_mux = {26'h0000000, ch_reg, sync_bit_reg, cal_mode_reg};
      A_STATUS: rd_mux = {30'h00000000, state_reg != ST_RUN,
                          result_ready_flag};
      A_DATA: rd_mux = {8'h00, data_reg};
      A_OFFSET: rd_mux = {8'h00, off_sel};
      A_GAIN: rd_mux = {8'h00, gain_sel};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else
      rdata <= bus.rd ? rd_mux : 32'h00000000;
  end
endmodule

// ---- dv/mod_src.sv ----
module mod_src (
  // Density select
  input wire logic dens,
  // Modulator stream
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Constant-density stream held between modulator samples
  assign mod_bit = dens;
endmodule

// ---- dv/sinc3_decimator_asserts.sv ----
module sinc3_decimator_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream and sync
  input wire logic mod_bit,
  input wire logic sync_n,
  // Register port
  input wire sinc3_pkg::bus_req_t bus,
  input wire logic [31:0] rdata,
  input wire logic result_ready_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import sinc3_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Decoded accesses
  wire rd_d = bus.rd && bus.addr == A_DATA;
  wire rd_s = bus.rd && bus.addr == A_STATUS;
  wire rd_c = bus.rd && (bus.addr == A_OFFSET || bus.addr == A_GAIN);
  wire cal_w = bus.wr && bus.addr == A_MODE &&
    bus.wdata[2:0] inside {CAL_FULL, CAL_SYS_ZS, CAL_SYS_FS,
    CAL_ZS, CAL_FS};
  // Accesses that may clear the ready flag
  wire clr_req = rd_d || cal_w;
  property p_idle;
    !bus.rd |=> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_unmap;
    bus.rd && bus.addr[2:1] == 2'b11 |=> rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_coef;
    rd_c |=> rdata[31:24] == 8'h0;
  endproperty
  a_coef: assert property (p_coef) else $error("coef width");
  property p_stat;
    rd_s |=> rdata[0] == $past(result_ready_flag) && rdata[31:2] == 30'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status bits");
  property p_rdclr;
    rd_d |=> !result_ready_flag;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("ready kept");
  property p_calclr;
    cal_w |=> !result_ready_flag;
  endproperty
  a_calclr: assert property (p_calclr) else $error("cal ready");
  property p_fall;
    $fell(result_ready_flag) |-> $past(clr_req);
  endproperty
  a_fall: assert property (p_fall) else $error("ready fell");
  property p_sync;
    !sync_n [*8] |-> !$rose(result_ready_flag);
  endproperty
  a_sync: assert property (p_sync) else $error("output in sync");
  property p_mode;
    bus.rd && bus.addr == A_MODE |=> rdata[31:6] == 26'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits");
  c_rdy: cover property ($rose(result_ready_flag));
  c_cal: cover property (cal_w);
  c_sync: cover property (!sync_n [*8]);
endmodule

// ---- dv/test_sinc3_decimator.sv ----
module test_sinc3_decimator;
  timeunit 1ns;
  timeprecision 1ps;
  import sinc3_pkg::*;
  localparam int P = 512;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sync_n = 1'b1;
  logic dens = 1'b1;
  logic mod_bit;
  bus_req_t bus = '0;
  logic [31:0] rdata;
  logic result_ready_flag;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] v;
  logic [31:0] d1;
  // Device and stream source
  sinc3_decimator sinc3_decimator_i (.clk(clk), .rst_n(rst_n),
    .mod_bit(mod_bit), .sync_n(sync_n), .bus(bus), .rdata(rdata),
    .result_ready_flag(result_ready_flag));
  mod_src mod_src_i (.dens(dens), .mod_bit(mod_bit));
  // Clock
  initial forever #4 clk = ~clk;
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic win(input string s, input int c, input int lo, input int hi);
    chk(s, 32'(c >= lo && c <= hi), 32'h1);
  endtask
  // Bus cycles
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rc(input logic [2:0] a, input logic [31:0] e, input string s);
    rd(a, v);
    chk(s, e, v);
  endtask
  // Waits bounded by cycle counts
  task automatic wait_rdy(output int c);
    c = 0;
    while (result_ready_flag !== 1'b1 && c < 8 * P)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task automatic wait_mode(output int c);
    logic [31:0] m;
    c = 0;
    m = 32'h1;
    while (m[2:0] !== 3'h0 && c < 16 * P)
    begin
      rd(A_MODE, m);
      c += 2;
    end
  endtask
  // Write, flush ready, then fetch the first settled word
  task automatic rsync(input logic [2:0] a, input logic [31:0] d);
    wr(a, d);
    rd(A_DATA, v);
    wait_rdy(n);
    win("settle", n, 2 * P, 3 * P + 64);
    rd(A_DATA, v);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rc(A_FILTER, 32'h100, "filter");
    rc(A_MODE, 32'h0, "mode");
    rc(A_STATUS, 32'h0, "status");
    rc(A_OFFSET, 32'h0, "offset");
    rc(A_GAIN, 32'h400000, "gain");
    rc(3'h7, 32'h0, "unmapped");
    wr(A_OFFSET, 32'hffabcdef);
    rc(A_OFFSET, 32'habcdef, "coef");
    wr(A_OFFSET, 32'h0);
    rsync(A_FILTER, 32'h4);
    d1 = v;
    rc(A_STATUS, 32'h0, "rd clear");
    wait_rdy(n);
    win("period", n, P - 16, P + 4);
    rc(A_DATA, d1, "steady");
    wr(A_OFFSET, 32'(d1[23:0] - 24'h10));
    wr(A_GAIN, 32'h800000);
    rsync(A_MODE, 32'h0);
    chk("corrected", 32'h20, v);
    rsync(A_MODE, 32'h10);
    chk("ch1", d1, v);
    wr(A_MODE, 32'h6);
    rc(A_STATUS, 32'h2, "cal busy");
    wait_mode(n);
    win("zs time", n, 2 * P, 3 * P + 64);
    rc(A_OFFSET, d1, "zs coef");
    wait_rdy(n);
    rc(A_DATA, 32'h0, "zero out");
    wr(A_MODE, 32'h7);
    wait_mode(n);
    win("fs time", n, 2 * P, 3 * P + 128);
    rc(A_GAIN, 32'hffffff, "fs coef");
    @(posedge clk);
    dens <= 1'b0;
    wr(A_MODE, 32'h10);
    wr(A_OFFSET, 32'h55);
    wr(A_MODE, 32'h11);
    wait_mode(n);
    win("full time", n, 5 * P, 6 * P + 128);
    rc(A_OFFSET, 32'h0, "full off");
    rc(A_GAIN, 32'hffffff, "full gain");
    rsync(A_FILTER, 32'h3004);
    chk("bip16", 32'h8000, v);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (4 * P) @(posedge clk);
    sync_n <= 1'b1;
    #1;
    chk("sync held", 32'h0, 32'(result_ready_flag));
    wait_rdy(n);
    win("sync settle", n, 2 * P, 3 * P + 64);
    // Filter held by the sync bit instead of the pin
    wr(A_MODE, 32'h18);
    rd(A_DATA, v);
    repeat (4 * P) @(posedge clk);
    #1;
    chk("bit held", 32'h0, 32'(result_ready_flag));
    rsync(A_MODE, 32'h10);
    // Full-scale step with a real span runs the gain divider on channel 2
    // Span 343 << 14 gives gain 2^46 over span, full scale then reads ones
    @(posedge clk);
    dens <= 1'b1;
    wr(A_FILTER, 32'h7);
    wr(A_MODE, 32'h23);
    wait_mode(n);
    win("div time", n, 14 * 128, 21 * 128 + 128);
    rc(A_GAIN, 32'hbf112a, "fs div");
    wait_rdy(n);
    rc(A_DATA, 32'hffffff, "span");
    give_verdict();
  end
endmodule
bind sinc3_decimator sinc3_decimator_asserts sinc3_decimator_asserts_i (
  .clk(clk), .rst_n(rst_n), .mod_bit(mod_bit), .sync_n(sync_n), .bus(bus),
  .rdata(rdata), .result_ready_flag(result_ready_flag));
